// *** core/dlw_pkg.sv ***
// Shared constants for the level DAC command decoder.
// Assumes a 29-bit serial command word and an APB register port.
//
// What this block does
// - Top command bit low writes the data field into the addressed register.
// - Top command bit high starts readback of the addressed register instead.
// - Four channel bits form a mask; one command updates any channel mix.
// - Kind code zero routes the command to the system or channel register decoder.
// - Kind code with only the low bit set writes the gain coefficient.
// - Kind code with only the high bit set writes the offset coefficient.
// - Kind code with both bits set writes the input level register.
// - Upper three DAC address bits choose the register set.
// - Lower three DAC address bits choose the DAC inside that set.
// - Low sixteen command bits carry the level or coefficient, top bit weightiest.
// - Corrected output code is recomputed only on an input level write.
// - Shared offset DAC has only an input register, reached with kind code three.
package dlw_pkg;

  // ==========================================================================
  // Command word layout
  localparam int CMD_W      = 29;
  localparam int RW_BIT     = 28;
  localparam int MASK_HI    = 27;
  localparam int MASK_LO    = 24;
  localparam int KIND_HI    = 23;
  localparam int KIND_LO    = 22;
  localparam int SET_HI     = 21;
  localparam int SET_LO     = 19;
  localparam int DAC_HI     = 18;
  localparam int DAC_LO     = 16;
  localparam int DATA_HI    = 15;
  localparam int NCH        = 4;
  localparam int NADDR      = 64;
  localparam logic [4:0] LAST_BIT = 5'h1c;

  // ==========================================================================
  // Register kinds
  typedef enum logic [1:0] {
    DLW_KIND_SYS  = 2'h0,
    DLW_KIND_GAIN = 2'h1,
    DLW_KIND_OFFS = 2'h2,
    DLW_KIND_X1   = 2'h3
  } dlw_kind_e;

  // ==========================================================================
  // Reset values and correction constants
  localparam logic [15:0] GAIN_RST  = 16'hffff;
  localparam logic [15:0] OFFS_RST  = 16'h8000;
  localparam logic [15:0] X1_RST    = 16'h0000;
  localparam logic [15:0] CODE_MID  = 16'h8000;
  localparam logic [15:0] CODE_MAX  = 16'hffff;

  // ==========================================================================
  // APB register map, byte addresses
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_LAST_CMD = 8'h08;
  localparam logic [7:0] REG_MEM_SEL  = 8'h0c;
  localparam logic [7:0] REG_MEM_DATA = 8'h10;
  localparam logic [7:0] REG_OFFS_DAC = 8'h14;
  localparam logic       CTRL_EN_RST  = 1'b1;

endpackage

// *** core/dlw_link_if.sv ***
// Carrier between the serial link logic and the decoder core.
// Assumes the word is stable whenever its toggle has changed.
`timescale 1ns/1ps
interface dlw_link_if;
  logic [28:0] cmd_word;
  logic        cmd_tgl;
  logic [15:0] rb_word;
  logic        rb_tgl;

  modport link (output cmd_word, output cmd_tgl, input rb_word, input rb_tgl);
  modport core (input cmd_word, input cmd_tgl, output rb_word, output rb_tgl);
endinterface

// *** core/dlw_link_rx.sv ***
// Serial command receiver on the link clock.
// Assumes the link clock runs only while the frame select is low.
`timescale 1ns/1ps
module dlw_link_rx
  import dlw_pkg::*;
(
  // Link side
  input  wire logic  sclk,
  input  wire logic  presetn,
  input  wire logic  sync_n,
  input  wire logic  sdi,
  output logic       sdo_q,
  // Core side
  dlw_link_if.link   lnk
);
  logic [4:0]  cnt_q;
  logic [27:0] sh_q;
  logic [1:0]  rb_sync_q;
  logic        rb_seen_q;
  logic [15:0] rb_sh_q;

  // ==========================================================================
  // Bit counter, cleared by the frame signal itself
  // Stops one past the last bit, so trailing edges publish nothing
  always_ff @(posedge sclk or negedge presetn or posedge sync_n) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
    end else if (sync_n) begin
      cnt_q <= 5'h00;
    end else if (cnt_q <= LAST_BIT) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // ==========================================================================
  // Shift in, top bit first; publish whole word with a toggle
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      sh_q         <= 28'h0000000;
      lnk.cmd_word <= 29'h00000000;
      lnk.cmd_tgl  <= 1'b0;
    end else if (!sync_n) begin
      sh_q <= {sh_q[26:0], sdi};
      if (cnt_q == LAST_BIT) begin
        lnk.cmd_word <= {sh_q, sdi};
        lnk.cmd_tgl  <= ~lnk.cmd_tgl;
      end
    end
  end

  // ==========================================================================
  // Readback word out on the frame after it arrives
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      rb_sync_q <= 2'h0;
      rb_seen_q <= 1'b0;
      rb_sh_q   <= 16'h0000;
      sdo_q     <= 1'b0;
    end else begin
      rb_sync_q <= {rb_sync_q[0], lnk.rb_tgl};
      if (!sync_n && cnt_q == 5'h00 && rb_sync_q[1] != rb_seen_q) begin
        rb_seen_q <= rb_sync_q[1];
        sdo_q     <= lnk.rb_word[15];
        rb_sh_q   <= {lnk.rb_word[14:0], 1'b0};
      end else if (!sync_n) begin
        sdo_q   <= rb_sh_q[15];
        rb_sh_q <= {rb_sh_q[14:0], 1'b0};
      end
    end
  end
endmodule

// *** core/dlw_calc.sv ***
// Gain and offset correction of one input level.
// Assumes gain full scale means unity and offset mid-code means zero.
`timescale 1ns/1ps
module dlw_calc
  import dlw_pkg::*;
(
  // Operands
  input  wire logic [15:0] level,
  input  wire logic [15:0] gain,
  input  wire logic [15:0] offs,
  // Result
  output logic      [15:0] code
);
  logic [32:0] prod;
  logic [17:0] sum;

  // Clamp keeps the result inside the DAC code range
  always_comb begin
    prod = 33'({17'h00000, level} * ({1'b0, gain} + 17'h00001));
    sum  = {2'h0, prod[31:16]} + {2'h0, offs} - {2'h0, CODE_MID};
    if (sum[17]) begin
      code = 16'h0000;
    end else if (sum[16]) begin
      code = CODE_MAX;
    end else begin
      code = sum[15:0];
    end
  end
endmodule

// *** core/dlw_top.sv ***
// Level DAC command decoder: serial link in, DAC level registers, APB view.
// Assumes an APB master on pclk and a host framing 29-bit words on sclk.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module dlw_top
  import dlw_pkg::*;
(
  // APB clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata_q,
  output logic               pready_q,
  output logic               pslverr_q,
  // Serial link
  input  wire logic          sclk,
  input  wire logic          sync_n,
  input  wire logic          sdi,
  output logic               sdo_q,
  // Corrected DAC updates and the uncorrected shared offset DAC level
  output logic [3:0]         upd_valid_q,
  output logic [5:0]         upd_addr_q,
  output logic [3:0][15:0]   upd_code_q,
  output logic [15:0]        offset_dac_q,
  // System and channel register decoder hand-off
  output logic               sysreg_valid_q,
  output logic [28:0]        sysreg_word_q
);
  import dlw_pkg::*;

  dlw_link_if lnk ();

  dlw_link_rx u_rx (
    .sclk    (sclk),
    .presetn (presetn),
    .sync_n  (sync_n),
    .sdi     (sdi),
    .sdo_q   (sdo_q),
    .lnk     (lnk.link)
  );

  // ==========================================================================
  // Command toggle crossing into pclk
  logic [2:0]  tgl_q;
  logic        cmd_v_q;
  logic [28:0] cmd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgl_q <= 3'h0;
    end else begin
      tgl_q <= {tgl_q[1:0], lnk.cmd_tgl};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_v_q <= 1'b0;
      cmd_q   <= 29'h00000000;
    end else begin
      cmd_v_q <= tgl_q[2] ^ tgl_q[1];
      if (tgl_q[2] ^ tgl_q[1]) begin
        cmd_q <= lnk.cmd_word;
      end
    end
  end

  // ==========================================================================
  // Field decode
  logic        ctrl_en_q;
  logic        is_read;
  logic [3:0]  mask;
  dlw_kind_e   kind;
  logic [2:0]  set_sel;
  logic [2:0]  dac_sel;
  logic [5:0]  addr;
  logic [15:0] data;
  logic        addr_ok;
  logic        offs_hit;
  logic        go;

  always_comb begin
    is_read  = cmd_q[RW_BIT];
    mask     = cmd_q[MASK_HI:MASK_LO];
    kind     = dlw_kind_e'(cmd_q[KIND_HI:KIND_LO]);
    set_sel  = cmd_q[SET_HI:SET_LO];
    dac_sel  = cmd_q[DAC_HI:DAC_LO];
    addr     = {set_sel, dac_sel};
    data     = cmd_q[DATA_HI:0];
    offs_hit = (addr == 6'h00);
    addr_ok  = 1'b0;
    // Codes outside the map are refused so reserved entries stay untouched
    if (set_sel == 3'h0) begin
      addr_ok = (dac_sel == 3'h0) && (kind == DLW_KIND_X1);
    end else if (set_sel == 3'h1 || set_sel == 3'h4 || set_sel == 3'h5) begin
      addr_ok = (dac_sel <= 3'h5);
    end else if (set_sel == 3'h2 || set_sel == 3'h3) begin
      addr_ok = (dac_sel == 3'h4) || (dac_sel == 3'h5);
    end
    go = cmd_v_q && ctrl_en_q && (mask != 4'h0);
  end

  // ==========================================================================
  // Per-channel register sets and correction
  logic [3:0][15:0] rd_val;
  logic [3:0][15:0] rb_val;
  logic [3:0][15:0] x2_val;
  logic [3:0]       calc_pend_q;
  logic [5:0]       calc_addr_q;
  logic [7:0]       sel_q;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [15:0] gain_mem [NADDR];
      logic [15:0] offs_mem [NADDR];
      logic [15:0] x1_mem   [NADDR];
      logic        wr;

      assign wr = go && !is_read && mask[g] && addr_ok && !offs_hit;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          for (int i = 0; i < NADDR; i++) begin
            gain_mem[i] <= GAIN_RST;
            offs_mem[i] <= OFFS_RST;
            x1_mem[i]   <= X1_RST;
          end
        end else if (wr) begin
          if (kind == DLW_KIND_GAIN) begin
            gain_mem[addr] <= data;
          end else if (kind == DLW_KIND_OFFS) begin
            offs_mem[addr] <= data;
          end else if (kind == DLW_KIND_X1) begin
            x1_mem[addr] <= data;
          end
        end
      end

      // Only an input level write arms the recompute
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          calc_pend_q[g] <= 1'b0;
        end else begin
          calc_pend_q[g] <= wr && (kind == DLW_KIND_X1);
        end
      end

      dlw_calc u_calc (
        .level (x1_mem[calc_addr_q]),
        .gain  (gain_mem[calc_addr_q]),
        .offs  (offs_mem[calc_addr_q]),
        .code  (x2_val[g])
      );

      // Link readback follows the command; the bus view follows the memory select
      always_comb begin
        if (kind == DLW_KIND_GAIN) begin
          rb_val[g] = gain_mem[addr];
        end else if (kind == DLW_KIND_OFFS) begin
          rb_val[g] = offs_mem[addr];
        end else begin
          rb_val[g] = x1_mem[addr];
        end
      end

      always_comb begin
        if (sel_q[7:6] == 2'h1) begin
          rd_val[g] = gain_mem[sel_q[5:0]];
        end else if (sel_q[7:6] == 2'h2) begin
          rd_val[g] = offs_mem[sel_q[5:0]];
        end else begin
          rd_val[g] = x1_mem[sel_q[5:0]];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          upd_valid_q[g] <= 1'b0;
          upd_code_q[g]  <= 16'h0000;
        end else begin
          upd_valid_q[g] <= calc_pend_q[g];
          if (calc_pend_q[g]) begin
            upd_code_q[g] <= x2_val[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calc_addr_q <= 6'h00;
    end else if (go && !is_read) begin
      calc_addr_q <= addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_addr_q <= 6'h00;
    end else if (calc_pend_q != 4'h0) begin
      upd_addr_q <= calc_addr_q;
    end
  end

  // ==========================================================================
  // Shared offset DAC and system register hand-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_dac_q <= X1_RST;
    end else if (go && !is_read && offs_hit && kind == DLW_KIND_X1) begin
      offset_dac_q <= data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysreg_valid_q <= 1'b0;
    end else begin
      sysreg_valid_q <= cmd_v_q && ctrl_en_q && (kind == DLW_KIND_SYS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysreg_word_q <= 29'h00000000;
    end else if (cmd_v_q && ctrl_en_q && kind == DLW_KIND_SYS) begin
      sysreg_word_q <= cmd_q;
    end
  end

  // ==========================================================================
  // Readback: offset DAC or lowest selected channel answers, word crosses by toggle
  logic [15:0] rb_pick;

  always_comb begin
    rb_pick = rb_val[0];
    if (offs_hit) begin
      rb_pick = offset_dac_q;
    end else if (mask[0]) begin
      rb_pick = rb_val[0];
    end else if (mask[1]) begin
      rb_pick = rb_val[1];
    end else if (mask[2]) begin
      rb_pick = rb_val[2];
    end else if (mask[3]) begin
      rb_pick = rb_val[3];
    end
  end

  // Word and toggle move together; the link side reads the word only after the toggle syncs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.rb_word <= 16'h0000;
      lnk.rb_tgl  <= 1'b0;
    end else if (go && is_read && kind != DLW_KIND_SYS && addr_ok) begin
      lnk.rb_word <= rb_pick;
      lnk.rb_tgl  <= ~lnk.rb_tgl;
    end
  end

  // ==========================================================================
  // Status counter and reserved-code flag
  logic [15:0] cmd_cnt_q;
  logic        rsvd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_cnt_q <= 16'h0000;
    end else if (cmd_v_q) begin
      cmd_cnt_q <= cmd_cnt_q + 16'h0001;
    end
  end

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsvd_q <= 1'b0;
    end else if (go && kind != DLW_KIND_SYS && !addr_ok) begin
      rsvd_q <= 1'b1;
    end else if (psel && penable && pready_q && pwrite && paddr == REG_STATUS) begin
      rsvd_q <= 1'b0;
    end
  end

  // ==========================================================================
  // APB slave, one wait state
  logic [31:0] rd_mux;
  logic        hit;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h00000000;
    if (paddr == REG_CTRL) begin
      rd_mux = {31'h00000000, ctrl_en_q};
    end else if (paddr == REG_STATUS) begin
      rd_mux = {15'h0000, rsvd_q, cmd_cnt_q};
    end else if (paddr == REG_LAST_CMD) begin
      rd_mux = {3'h0, cmd_q};
    end else if (paddr == REG_MEM_SEL) begin
      rd_mux = {24'h000000, sel_q};
    end else if (paddr == REG_MEM_DATA) begin
      rd_mux = {16'h0000, rd_val[0]};
    end else if (paddr == REG_OFFS_DAC) begin
      rd_mux = {16'h0000, offset_dac_q};
    end else begin
      hit = 1'b0;
    end
  end

  // Ready rises in the second access cycle and drops in the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit;
      prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_q <= CTRL_EN_RST;
    end else if (psel && penable && pready_q && pwrite && paddr == REG_CTRL) begin
      ctrl_en_q <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 8'h00;
    end else if (psel && penable && pready_q && pwrite && paddr == REG_MEM_SEL) begin
      sel_q <= pwdata[7:0];
    end
  end
endmodule

// *** sim/dlw_host_model.sv ***
// Host controller model framing 29-bit commands on the serial link.
// Assumes the decoder samples data on the rising link clock edge.
`timescale 1ns/1ps
module dlw_host_model (
  // Serial link
  output logic       sclk,
  output logic       sync_n,
  output logic       sdi,
  input  wire logic  sdo_q
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
  end
  // Sends one frame and returns the first 16 readback bits
  task automatic send(input logic [28:0] w, output logic [15:0] rb);
    rb = 16'h0;
    sync_n = 1'b0;
    #31;
    for (int i = 28; i >= 0; i--) begin
      sdi = w[i];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      if (i > 12) rb = {rb[14:0], sdo_q};
    end
    #31 sync_n = 1'b1;
    // Released line must not keep its last level
    sdi = ~sdi;
    #400;
  endtask
endmodule

// *** sim/dlw_top_props.sv ***
// Assertion checker for the level DAC decoder top.
// Sees top ports only; bound from the testbench top file.
`timescale 1ns/1ps
module dlw_top_props (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Observed outputs
  input wire logic [3:0]        upd_valid_q,
  input wire logic [5:0]        upd_addr_q,
  input wire logic [3:0][15:0]  upd_code_q,
  input wire logic              sysreg_valid_q,
  input wire logic [28:0]       sysreg_word_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Decode outputs
  AST_UPD_PULSE: assert property (|upd_valid_q |=> upd_valid_q == 4'h0)
    else $error("update pulse longer than one cycle");
  AST_SYS_PULSE: assert property (sysreg_valid_q |=> !sysreg_valid_q)
    else $error("system hand-off pulse too long");
  AST_SYS_KIND: assert property (sysreg_valid_q |-> sysreg_word_q[23:22] == 2'h0)
    else $error("hand-off word has nonzero kind");
  AST_SYS_NO_UPD: assert property (sysreg_valid_q |-> upd_valid_q == 4'h0)
    else $error("kind zero also updated a DAC");
  AST_UPD_SET: assert property (|upd_valid_q |-> upd_addr_q[5:3] inside {[3'h1:3'h5]})
    else $error("update for a reserved register set");
  AST_CODE_HOLD: assert property ($changed(upd_code_q) |-> |upd_valid_q)
    else $error("code changed without update");
  AST_CH0_MASK: assert property ($changed(upd_code_q[0]) |-> upd_valid_q[0])
    else $error("channel 0 code changed outside mask");
  AST_CH3_MASK: assert property ($changed(upd_code_q[3]) |-> upd_valid_q[3])
    else $error("channel 3 code changed outside mask");
  AST_SYSWORD_HOLD: assert property ($changed(sysreg_word_q) |-> sysreg_valid_q)
    else $error("hand-off word changed without pulse");
  cover property (upd_valid_q == 4'hf);
  cover property (|upd_valid_q && upd_valid_q != 4'hf);
  cover property (sysreg_valid_q);
endmodule

// *** sim/dlw_top_tb.sv ***
// Self-checking bench for the level DAC command decoder.
// Drives APB on pclk and serial frames through the host model.
`timescale 1ns/1ps
module dlw_top_tb;
  import dlw_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata_q, rd;
  logic              sclk, sync_n, sdi, sdo_q, sysreg_valid_q, er, en;
  logic [3:0]        upd_valid_q, last_mask;
  logic [5:0]        upd_addr_q, last_addr, a;
  logic [3:0][15:0]  upd_code_q, last_code;
  logic [15:0]       offset_dac_q, rb, rb2;
  logic [28:0]       sysreg_word_q, last_sys;
  logic [31:0]       rs;
  int                mismatches, checks_done, upd_cnt, sys_cnt;
  int                mg[4][64], mc[4][64], mx[4][64];
  logic [5:0]        legal[6] = '{6'h08, 6'h0d, 6'h14, 6'h1d, 6'h20, 6'h2d};

  dlw_top u_dlw_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
    .sdo_q(sdo_q), .upd_valid_q(upd_valid_q), .upd_addr_q(upd_addr_q),
    .upd_code_q(upd_code_q), .offset_dac_q(offset_dac_q),
    .sysreg_valid_q(sysreg_valid_q), .sysreg_word_q(sysreg_word_q));
  dlw_host_model u_host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo_q(sdo_q));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ==========================================================================
  // Output monitor
  always @(posedge pclk) begin
    if (upd_valid_q !== 4'h0) begin
      upd_cnt++;
      last_mask = upd_valid_q;
      last_addr = upd_addr_q;
      last_code = upd_code_q;
    end
    if (sysreg_valid_q === 1'b1) begin
      sys_cnt++;
      last_sys = sysreg_word_q;
    end
  end
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic int calc(int x, int g, int c);
    longint t;
    t = ((longint'(x) * (g + 1)) / 65536) + c - 32768;
    return (t < 0) ? 0 : (t > 65535) ? 65535 : int'(t);
  endfunction
  function automatic logic [28:0] cmd(logic r, logic [3:0] m, logic [1:0] k, logic [5:0] ad,
                                      logic [15:0] d);
    return {r, m, k, ad, d};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    if (pready_q !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: bus timeout", $time);
      give_verdict();
    end
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [28:0] w);
    int u0, s0, n;
    logic [1:0] k;
    logic [3:0] m;
    logic ok, ev;
    k = w[23:22];
    m = w[27:24];
    ok = (w[21:16] == 6'h0 && k == 2'h3) || (k != 2'h0 && ((w[21:19] inside {3'h1, 3'h4,
         3'h5} && w[18:16] < 3'h6) || (w[21:19] inside {3'h2, 3'h3} && w[18:17] == 2'h2)));
    ok = ok && m != 4'h0 && !w[28] && en;
    ev = (k == 2'h0 && en) || (ok && k == 2'h3 && w[21:16] != 6'h00);
    u0 = upd_cnt;
    s0 = sys_cnt;
    u_host.send(w, rb);
    n = 0;
    while (ev && upd_cnt == u0 && sys_cnt == s0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (ev && upd_cnt == u0 && sys_cnt == s0) begin
      mismatches++;
      $display("Error at %0t: frame timeout", $time);
      give_verdict();
    end
    repeat (4) @(posedge pclk);
    if (k == 2'h0 && en) begin
      chk(sys_cnt - s0, 1);
      chk(last_sys, w);
    end else if (ok && w[21:16] == 6'h0) chk(offset_dac_q, w[15:0]);
    else if (ok) begin
      for (int c = 0; c < 4; c++) begin
        if (m[c] && k == 2'h1) mg[c][w[21:16]] = w[15:0];
        if (m[c] && k == 2'h2) mc[c][w[21:16]] = w[15:0];
        if (m[c] && k == 2'h3) mx[c][w[21:16]] = w[15:0];
      end
      chk(upd_cnt - u0, (k == 2'h3) ? 1 : 0);
      if (k == 2'h3) begin
        chk(last_mask, m);
        chk(last_addr, w[21:16]);
        for (int c = 0; c < 4; c++) begin
          if (m[c]) chk(last_code[c], calc(mx[c][w[21:16]], mg[c][w[21:16]],
                                           mc[c][w[21:16]]));
        end
      end
    end else chk(upd_cnt - u0, 0);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    rs = 32'hc91e0c14;
    en = 1'b1;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 64; i++) begin
        mg[c][i] = 16'hffff;
        mc[c][i] = 16'h8000;
        mx[c][i] = 0;
      end
    end
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h40, 32'h0);
    chk(er, 32'h1);
    $display("test registers done");
    a = legal[0];
    frame(cmd(1'b0, 4'hf, 2'h1, a, 16'(rnd() >> 16)));
    frame(cmd(1'b0, 4'hf, 2'h2, a, 16'(rnd() >> 16)));
    frame(cmd(1'b0, 4'h5, 2'h3, a, 16'(rnd() >> 16)));
    for (int k = 1; k < 4; k++) begin
      apb(1'b1, REG_MEM_SEL, {24'h0, k[1:0], a});
      apb(1'b0, REG_MEM_DATA, 32'h0);
      chk(rd[15:0], (k == 1) ? mg[0][a] : (k == 2) ? mc[0][a] : mx[0][a]);
    end
    $display("test kinds done");
    repeat (14) frame(cmd(1'b0, 4'(rnd()), 2'(rnd()), legal[rnd() % 6], 16'(rnd())));
    $display("test random done");
    frame(cmd(1'b0, 4'h0, 2'h3, legal[1], 16'h1234));
    frame(cmd(1'b0, 4'h9, 2'h3, 6'h00, 16'h5a5a));
    frame(cmd(1'b0, 4'hf, 2'h3, 6'h3f, 16'h4321));
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[16], 1'b1);
    apb(1'b1, REG_CTRL, 32'h0);
    en = 1'b0;
    frame(cmd(1'b0, 4'hf, 2'h3, legal[2], 16'h7777));
    apb(1'b1, REG_CTRL, 32'h1);
    en = 1'b1;
    $display("test refusals done");
    a = legal[3];
    frame(cmd(1'b0, 4'hf, 2'h3, a, 16'(rnd() | 32'h1)));
    frame(cmd(1'b1, 4'h2, 2'h3, a, 16'h0));
    frame(cmd(1'b0, 4'h0, 2'h3, a, 16'h0));
    rb2 = rb;
    frame(cmd(1'b0, 4'h0, 2'h3, a, 16'h0));
    chk(rb2 === mx[1][a] || rb === mx[1][a], 1);
    $display("test readback done");
    give_verdict();
  end
  initial begin
    #600000;
    mismatches++;
    $display("Error at %0t: run timeout", $time);
    give_verdict();
  end
endmodule

bind dlw_top dlw_top_props u_dlw_top_props (.pclk(pclk), .presetn(presetn),
  .upd_valid_q(upd_valid_q), .upd_addr_q(upd_addr_q), .upd_code_q(upd_code_q),
  .sysreg_valid_q(sysreg_valid_q), .sysreg_word_q(sysreg_word_q));
